// ==== verilog/ebw_pkg.sv ====
// Purpose: Shared constants for the external bus area and wait-state controller
// Assumes: One 40 MHz clock, APB register access with 32-bit data
// Notes: Register indices are kept as printed; byte address is four times the index
package ebw_pkg;

  // Clock rate in MHz, for reference by timing-derived constants
  localparam int unsigned CLK_MHZ = 40;

  // APB address width: 16-bit register index shifted up by two bits
  localparam int unsigned APB_AW = 18;

  // Printed register indices
  localparam logic [15:0] IDX_ACCESS_STATE = 16'hFFED;
  localparam logic [15:0] IDX_WAIT_CONTROL = 16'hFFEE;
  localparam logic [15:0] IDX_WAIT_ENABLE = 16'hFFEF;

  // Byte addresses on the APB
  localparam logic [APB_AW-1:0] ADDR_ACCESS_STATE = {IDX_ACCESS_STATE, 2'b00};
  localparam logic [APB_AW-1:0] ADDR_WAIT_CONTROL = {IDX_WAIT_CONTROL, 2'b00};
  localparam logic [APB_AW-1:0] ADDR_WAIT_ENABLE = {IDX_WAIT_ENABLE, 2'b00};

  // Reset values
  localparam logic [7:0] RST_ACCESS_STATE = 8'hFF;
  localparam logic [7:0] RST_WAIT_ENABLE = 8'hFF;
  localparam logic [7:0] RST_WAIT_CONTROL = 8'hF3;

  // Field layout of the wait control register
  localparam int unsigned CTL_MODE_HI = 3;
  localparam int unsigned CTL_MODE_LO = 2;
  localparam int unsigned CTL_CNT_HI = 1;
  localparam int unsigned CTL_CNT_LO = 0;
  localparam logic [3:0] CTL_RSVD_VAL = 4'hF;

  // External address space: 20 bits, eight areas of 128 kbytes
  localparam int unsigned EXT_AW = 20;
  localparam int unsigned AREA_LSB = 17;
  localparam int unsigned NUM_AREAS = 8;
  localparam int unsigned EXT_DW = 8;

  // Fixed state count of on-chip accesses
  localparam logic [1:0] ONCHIP_STATES = 2'h2;

  // Global wait mode field encoding
  localparam logic [1:0] WMODE_PROG = 2'h0;
  localparam logic [1:0] WMODE_NONE = 2'h1;
  localparam logic [1:0] WMODE_PIN1 = 2'h2;
  localparam logic [1:0] WMODE_AUTO = 2'h3;

  // Effective wait mode of one bus cycle
  typedef enum logic [2:0] {
    EM_NOWAIT = 3'b000,
    EM_PIN0 = 3'b001,
    EM_PROG = 3'b010,
    EM_PIN1 = 3'b011,
    EM_AUTO = 3'b100
  } ebw_emode_e;

  // Bus state machine
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_T1 = 3'b001,
    ST_SEC = 3'b010,
    ST_WAIT = 3'b011,
    ST_T3 = 3'b100,
    ST_ONCHIP = 3'b101
  } ebw_state_e;

endpackage

// ==== verilog/ebw_wait_insert_unit.sv ====
// Purpose: Decides per bus state whether one more wait state follows
// Assumes: Caller pulses sec_state in the second bus state and in_wait in each wait state
// Notes: Wait pin is sampled at the clock edge that ends the state
`timescale 1ns/1ps
module ebw_wait_insert_unit
  import ebw_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sec_state,
  input wire logic in_wait,
  input wire ebw_emode_e emode,
  input wire logic [1:0] wait_count,
  input wire logic wait_n,
  output logic go_wait
);

  logic [1:0] rem_ff; // Counted wait states still to come
  logic [1:0] nxt_rem;
  logic pin_ff; // Pin may extend once the count is used up
  logic nxt_pin;
  wire cnt_zero = (wait_count == 2'h0);
  wire [1:0] cnt_less = wait_count - 2'h1;

  // Decision in the second bus state and in each wait state
  always_comb begin
    go_wait = 1'b0;
    nxt_rem = rem_ff;
    nxt_pin = pin_ff;
    if (sec_state) begin
      nxt_rem = 2'h0;
      nxt_pin = 1'b0;
      case (emode)
        EM_PIN0: begin
          go_wait = !wait_n; // RQ7
          nxt_pin = 1'b1;
        end
        EM_PROG: begin
          go_wait = !cnt_zero; // RQ11
          nxt_rem = cnt_less;
        end
        EM_PIN1: begin
          // Zero count behaves as the pin-only mode
          go_wait = cnt_zero ? !wait_n : 1'b1; // RQ8 RQ9
          nxt_rem = cnt_zero ? 2'h0 : cnt_less;
          nxt_pin = 1'b1;
        end
        EM_AUTO: begin
          go_wait = !wait_n && !cnt_zero; // RQ10
          nxt_rem = cnt_less;
        end
        default: begin
          go_wait = 1'b0; // RQ3
        end
      endcase
    end else if (in_wait) begin
      if (rem_ff != 2'h0) begin
        go_wait = 1'b1; // RQ14
        nxt_rem = rem_ff - 2'h1;
      end else begin
        go_wait = pin_ff && !wait_n; // RQ7 RQ8
      end
    end
  end

  // Count state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rem_ff <= 2'h0;
      pin_ff <= 1'b0;
    end else begin
      rem_ff <= nxt_rem;
      pin_ff <= nxt_pin;
    end
  end

endmodule

// ==== verilog/ebw_bus_ctrl.sv ====
// Purpose: External bus controller with eight areas and per-area wait control
// Assumes: CPU holds a request until done; APB slave with zero-wait access phase
// Notes: One clock per bus state; wait pin sampled at the edge closing a state
//
// Overview of operation
// [RQ1] Eight areas of 128 kbytes each
// [RQ2] External data bus always 8 bits
// [RQ3] Two-state areas never get wait states
// [RQ4] Three-state areas take three base states
// [RQ5] Enable bit and mode field pick mode
// [RQ6] Per-area bits, one shared mode field
// [RQ7] Pin mode 0 waits while pin low
// [RQ8] Pin mode 1: count then pin extension
// [RQ9] Pin mode 1, count zero acts as 0
// [RQ10] Auto mode: pin low adds count exactly
// [RQ11] Programmable mode always inserts count
// [RQ12] Reset loads FF, F3, FF
// [RQ13] Register writes affect only later cycles
// [RQ14] Two-bit count gives 0 to 3 waits
// [RQ15] On-chip accesses ignore area settings
// [RQ16] Strobes held through wait states
`timescale 1ns/1ps
module ebw_bus_ctrl
  import ebw_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU access port
  input wire logic cpu_req,
  input wire logic cpu_onchip,
  input wire logic cpu_wr,
  input wire logic [EXT_AW-1:0] cpu_addr,
  input wire logic [EXT_DW-1:0] cpu_wdata,
  output logic cpu_done,
  output logic [EXT_DW-1:0] cpu_rdata,
  // External bus
  output logic [EXT_AW-1:0] ext_addr,
  output logic [EXT_DW-1:0] ext_data_o,
  output logic ext_data_oe_n,
  input wire logic [EXT_DW-1:0] ext_data_i,
  output logic addr_strobe_n,
  output logic rd_n,
  output logic wr_n,
  input wire logic wait_n
);

  // Registers seen by software
  logic [7:0] access_state_reg_ff; // One state-select bit per area
  logic [7:0] wait_enable_reg_ff; // One wait-control enable per area
  logic [1:0] wait_mode_ff; // Shared mode field
  logic [1:0] wait_count_ff; // Shared count field

  // Per-cycle latched configuration
  logic cyc_ast_ff; // Three-state area
  logic cyc_wce_ff; // Wait control enabled
  logic [1:0] cyc_mode_ff;
  logic [1:0] cyc_cnt_ff;
  logic cyc_wr_ff;
  logic [EXT_DW-1:0] cyc_wdata_ff;
  logic [EXT_AW-1:0] ext_addr_ff;
  logic [1:0] onchip_cnt_ff; // On-chip state counter

  // Bus state machine
  ebw_state_e state_ff;
  ebw_state_e nxt_state;

  // Outputs from flip-flops
  logic addr_strobe_n_ff;
  logic rd_n_ff;
  logic wr_n_ff;
  logic data_oe_n_ff;
  logic done_ff;
  logic [EXT_DW-1:0] rdata_ff;
  logic [31:0] prdata_ff;

  // APB decode
  wire apb_setup = psel && !penable;
  wire apb_access = psel && penable;
  wire hit_ast = (paddr == ADDR_ACCESS_STATE);
  wire hit_ctl = (paddr == ADDR_WAIT_CONTROL);
  wire hit_wce = (paddr == ADDR_WAIT_ENABLE);
  wire hit_any = hit_ast || hit_ctl || hit_wce;
  wire wr_lane0 = apb_access && pwrite && pstrb[0];
  wire [7:0] ctl_view = {CTL_RSVD_VAL, wait_mode_ff, wait_count_ff};
  wire [7:0] rd_mux = hit_ast ? access_state_reg_ff :
                      hit_ctl ? ctl_view :
                      hit_wce ? wait_enable_reg_ff : 8'h00;

  assign pready = apb_access;
  assign pslverr = apb_access && !hit_any;
  assign prdata = prdata_ff;

  // Area decode of the incoming request
  wire [2:0] req_area = cpu_addr[EXT_AW-1:AREA_LSB]; // RQ1
  wire take_req = (state_ff == ST_IDLE) && cpu_req && !done_ff;

  // Effective mode of the cycle in progress
  ebw_emode_e cyc_emode;
  wire ext_state = (state_ff == ST_T1) || (state_ff == ST_SEC) ||
                   (state_ff == ST_WAIT) || (state_ff == ST_T3);
  wire last_state;
  wire go_wait;

  assign cyc_emode = !cyc_ast_ff ? EM_NOWAIT : // RQ3
                     !cyc_wce_ff ? EM_PIN0 : // RQ5
                     (cyc_mode_ff == WMODE_PROG) ? EM_PROG :
                     (cyc_mode_ff == WMODE_PIN1) ? EM_PIN1 :
                     (cyc_mode_ff == WMODE_AUTO) ? EM_AUTO : EM_NOWAIT; // RQ6

  assign last_state = ((state_ff == ST_SEC) && !cyc_ast_ff) ||
                      (state_ff == ST_T3) ||
                      ((state_ff == ST_ONCHIP) && (onchip_cnt_ff == 2'h1));

  // Wait decision unit
  ebw_wait_insert_unit u_wait (
    .clk(clk),
    .rst_n(rst_n),
    .sec_state((state_ff == ST_SEC) && cyc_ast_ff),
    .in_wait(state_ff == ST_WAIT),
    .emode(cyc_emode),
    .wait_count(cyc_cnt_ff),
    .wait_n(wait_n),
    .go_wait(go_wait)
  );

  // Next-state logic
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (take_req) begin
          nxt_state = cpu_onchip ? ST_ONCHIP : ST_T1; // RQ15
        end
      end
      ST_T1: begin
        nxt_state = ST_SEC;
      end
      ST_SEC: begin
        if (!cyc_ast_ff) begin
          nxt_state = ST_IDLE; // RQ3
        end else begin
          nxt_state = go_wait ? ST_WAIT : ST_T3; // RQ4
        end
      end
      ST_WAIT: begin
        nxt_state = go_wait ? ST_WAIT : ST_T3;
      end
      ST_T3: begin
        nxt_state = ST_IDLE;
      end
      ST_ONCHIP: begin
        if (onchip_cnt_ff == 2'h1) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Strobe targets for the coming state
  wire nxt_ext = (nxt_state == ST_T1) || (nxt_state == ST_SEC) ||
                 (nxt_state == ST_WAIT) || (nxt_state == ST_T3);
  wire nxt_late = nxt_ext && (nxt_state != ST_T1);
  wire nxt_wr = take_req ? cpu_wr : cyc_wr_ff;

  // Software registers, written in the APB access phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      access_state_reg_ff <= RST_ACCESS_STATE; // RQ12
      wait_enable_reg_ff <= RST_WAIT_ENABLE;
      wait_mode_ff <= RST_WAIT_CONTROL[CTL_MODE_HI:CTL_MODE_LO];
      wait_count_ff <= RST_WAIT_CONTROL[CTL_CNT_HI:CTL_CNT_LO];
    end else if (wr_lane0) begin
      if (hit_ast) begin
        access_state_reg_ff <= pwdata[7:0];
      end
      if (hit_wce) begin
        wait_enable_reg_ff <= pwdata[7:0];
      end
      if (hit_ctl) begin
        wait_mode_ff <= pwdata[CTL_MODE_HI:CTL_MODE_LO];
        wait_count_ff <= pwdata[CTL_CNT_HI:CTL_CNT_LO];
      end
    end
  end

  // Read data captured in the setup phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata_ff <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata_ff <= {24'h00_0000, rd_mux};
    end
  end

  // Latch area settings at cycle start so later writes wait their turn
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cyc_ast_ff <= 1'b0;
      cyc_wce_ff <= 1'b0;
      cyc_mode_ff <= 2'h0;
      cyc_cnt_ff <= 2'h0;
      cyc_wr_ff <= 1'b0;
      cyc_wdata_ff <= 8'h00;
      ext_addr_ff <= 20'h0_0000;
    end else if (take_req) begin
      cyc_ast_ff <= access_state_reg_ff[req_area]; // RQ13 RQ6
      cyc_wce_ff <= wait_enable_reg_ff[req_area];
      cyc_mode_ff <= wait_mode_ff;
      cyc_cnt_ff <= wait_count_ff;
      cyc_wr_ff <= cpu_wr;
      cyc_wdata_ff <= cpu_wdata; // RQ2
      ext_addr_ff <= cpu_addr;
    end
  end

  // State register and on-chip state counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      onchip_cnt_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      onchip_cnt_ff <= (take_req && cpu_onchip) ? ONCHIP_STATES :
                       (onchip_cnt_ff != 2'h0) ? onchip_cnt_ff - 2'h1 : 2'h0;
    end
  end

  // Strobes follow the coming state; held low through every wait state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_strobe_n_ff <= 1'b1;
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
      data_oe_n_ff <= 1'b1;
    end else begin
      addr_strobe_n_ff <= !nxt_ext; // RQ16
      rd_n_ff <= !(nxt_ext && !nxt_wr);
      wr_n_ff <= !(nxt_late && nxt_wr);
      data_oe_n_ff <= !(nxt_ext && nxt_wr);
    end
  end

  // Completion pulse and read data capture
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      done_ff <= last_state;
      if (last_state && ext_state && !cyc_wr_ff) begin
        rdata_ff <= ext_data_i; // RQ2
      end
    end
  end

  assign ext_addr = ext_addr_ff;
  assign ext_data_o = cyc_wdata_ff;
  assign ext_data_oe_n = data_oe_n_ff;
  assign addr_strobe_n = addr_strobe_n_ff;
  assign rd_n = rd_n_ff;
  assign wr_n = wr_n_ff;
  assign cpu_done = done_ff;
  assign cpu_rdata = rdata_ff;

  // Helper: wait states seen in the current cycle
  logic [3:0] wait_seen_ff;
  always_ff @(posedge clk) begin
    if (!rst_n || state_ff == ST_T1) begin
      wait_seen_ff <= 4'h0;
    end else if (state_ff == ST_WAIT && wait_seen_ff != 4'hF) begin
      wait_seen_ff <= wait_seen_ff + 4'h1;
    end
  end

  a_two_state_len: assert property (@(posedge clk) disable iff (!rst_n) // RQ3
    (state_ff == ST_T1 && !cyc_ast_ff) |=> (state_ff == ST_SEC) ##1 (state_ff == ST_IDLE))
    else $error("two-state cycle not two states");

  a_three_state_base: assert property (@(posedge clk) disable iff (!rst_n) // RQ4
    (state_ff == ST_SEC && cyc_ast_ff) |=> (state_ff == ST_WAIT || state_ff == ST_T3))
    else $error("three-state cycle skipped third state");

  a_prog_count: assert property (@(posedge clk) disable iff (!rst_n) // RQ11
    (state_ff == ST_T3 && cyc_emode == EM_PROG) |-> (wait_seen_ff == {2'b00, cyc_cnt_ff}))
    else $error("programmable wait count wrong");

  a_pin0_hold: assert property (@(posedge clk) disable iff (!rst_n) // RQ7
    ((state_ff == ST_SEC || state_ff == ST_WAIT) && cyc_emode == EM_PIN0 && !wait_n)
    |=> (state_ff == ST_WAIT))
    else $error("pin mode 0 did not wait");

  a_pin1_min: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
    (state_ff == ST_T3 && cyc_emode == EM_PIN1) |-> (wait_seen_ff >= {2'b00, cyc_cnt_ff}))
    else $error("pin mode 1 short of count");

  a_auto_exact: assert property (@(posedge clk) disable iff (!rst_n) // RQ10
    (state_ff == ST_T3 && cyc_emode == EM_AUTO) |->
    (wait_seen_ff == 4'h0 || wait_seen_ff == {2'b00, cyc_cnt_ff}))
    else $error("auto wait count wrong");

  a_none_mode: assert property (@(posedge clk) disable iff (!rst_n) // RQ5
    (state_ff == ST_SEC && cyc_emode == EM_NOWAIT && cyc_ast_ff) |=> (state_ff == ST_T3))
    else $error("no-wait mode inserted wait");

  a_cfg_stable: assert property (@(posedge clk) disable iff (!rst_n) // RQ13
    (ext_state && state_ff != ST_T1) |-> ($stable(cyc_ast_ff) && $stable(cyc_wce_ff)))
    else $error("cycle settings changed mid-cycle");

  a_strobe_hold: assert property (@(posedge clk) disable iff (!rst_n) // RQ16
    (ext_state) |-> (!addr_strobe_n && (rd_n != wr_n || state_ff == ST_T1)))
    else $error("strobe released during cycle");

  a_onchip_quiet: assert property (@(posedge clk) disable iff (!rst_n) // RQ15
    (state_ff == ST_ONCHIP) |-> (addr_strobe_n && rd_n && wr_n))
    else $error("on-chip access drove strobes");

  a_reset_vals: assert property (@(posedge clk) disable iff (!rst_n) // RQ12
    $rose(rst_n) |-> (access_state_reg_ff == RST_ACCESS_STATE &&
    wait_enable_reg_ff == RST_WAIT_ENABLE && ctl_view == RST_WAIT_CONTROL))
    else $error("reset values wrong");

  c_two_state: cover property (@(posedge clk) state_ff == ST_SEC && !cyc_ast_ff);
  c_prog_waits: cover property (@(posedge clk) state_ff == ST_T3 && wait_seen_ff == 4'h3);
  c_pin1_ext: cover property (@(posedge clk)
    state_ff == ST_T3 && cyc_emode == EM_PIN1 && wait_seen_ff > {2'b00, cyc_cnt_ff});
  c_onchip: cover property (@(posedge clk) state_ff == ST_ONCHIP);

endmodule

// ==== sim/ebw_ext_mem.sv ====
// Purpose: Byte-wide external memory that can hold the wait request low
// Assumes: Strobes, address and write data come from the bus controller
// Notes: Wait pin is driven high by the model whenever it is not holding it low
`timescale 1ns/1ps
module ebw_ext_mem
  import ebw_pkg::*;
(
  input wire logic clk,
  input wire logic [EXT_AW-1:0] ext_addr,
  input wire logic [EXT_DW-1:0] ext_data_o,
  input wire logic ext_data_oe_n,
  input wire logic addr_strobe_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [3:0] low_len,
  output logic [EXT_DW-1:0] ext_data_i,
  output logic wait_n
);
  logic [EXT_DW-1:0] mem_ff [0:31]; // Storage by area and low address bits
  logic [3:0] state_cnt_ff; // Bus states since the address strobe fell
  logic [EXT_DW-1:0] last_ff; // Last value seen on the read bus
  wire logic [4:0] idx = {ext_addr[19:17], ext_addr[1:0]}; // Storage index

  // Pin low from the second bus state on, for low_len states
  assign wait_n = ~(!addr_strobe_n && state_cnt_ff >= 4'h1 && state_cnt_ff <= low_len);
  // Released read bus toggles so no stale byte can pass for good data
  assign ext_data_i = !rd_n ? mem_ff[idx] : ~last_ff;

  // Count states of the current cycle, store written bytes
  always_ff @(posedge clk) begin
    state_cnt_ff <= addr_strobe_n ? 4'h0 : state_cnt_ff + 4'h1;
    last_ff <= ext_data_i;
    if (!wr_n && !ext_data_oe_n) begin
      mem_ff[idx] <= ext_data_o;
    end
  end
endmodule

// ==== sim/ebw_bus_ctrl_test.sv ====
// Purpose: Self-checking bench for the area and wait-state bus controller
// Assumes: Zero-wait APB slave, CPU request held until done
// Notes: Latency counts edges from the edge that raises the request
`timescale 1ns/1ps
module ebw_bus_ctrl_test
  import ebw_pkg::*;
();
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic [3:0] pstrb = 4'hF, low_len = 4'h0;
  logic cpu_req = 0, cpu_onchip = 0, cpu_wr = 0, pready, pslverr, cpu_done, e;
  logic [EXT_AW-1:0] cpu_addr = '0, ext_addr, a;
  logic [EXT_DW-1:0] cpu_wdata = '0, cpu_rdata, ext_data_o, ext_data_i;
  logic ext_data_oe_n, addr_strobe_n, rd_n, wr_n, wait_n;
  int bad_count = 0, checks = 0;
  // One row: area settings, pin low length, area, expected latency
  typedef struct packed {
    logic ast; logic wce; logic [1:0] mode; logic [1:0] cnt;
    logic [3:0] low; logic [2:0] area; logic [3:0] lat;
  } ebw_row_s;
  ebw_row_s rows [11] = '{
    '{1'b0, 1'b1, WMODE_PROG, 2'h3, 4'h5, 3'h0, 4'h3},
    '{1'b1, 1'b0, WMODE_PROG, 2'h3, 4'h2, 3'h1, 4'h6},
    '{1'b1, 1'b1, WMODE_PROG, 2'h2, 4'h3, 3'h2, 4'h6},
    '{1'b1, 1'b1, WMODE_NONE, 2'h3, 4'h2, 3'h3, 4'h4},
    '{1'b1, 1'b1, WMODE_PIN1, 2'h1, 4'h3, 3'h4, 4'h7},
    '{1'b1, 1'b1, WMODE_PIN1, 2'h2, 4'h0, 3'h5, 4'h6},
    '{1'b1, 1'b1, WMODE_PIN1, 2'h0, 4'h2, 3'h6, 4'h6},
    '{1'b1, 1'b1, WMODE_AUTO, 2'h2, 4'h5, 3'h7, 4'h6},
    '{1'b1, 1'b1, WMODE_AUTO, 2'h3, 4'h0, 3'h0, 4'h4},
    '{1'b1, 1'b1, WMODE_PROG, 2'h0, 4'h0, 3'h1, 4'h4},
    '{1'b1, 1'b1, WMODE_PROG, 2'h1, 4'h4, 3'h2, 4'h5}};

  always #12.5 clk = ~clk; // 40 MHz

  ebw_bus_ctrl i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_req(cpu_req), .cpu_onchip(cpu_onchip),
    .cpu_wr(cpu_wr), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_done(cpu_done),
    .cpu_rdata(cpu_rdata), .ext_addr(ext_addr), .ext_data_o(ext_data_o),
    .ext_data_oe_n(ext_data_oe_n), .ext_data_i(ext_data_i), .addr_strobe_n(addr_strobe_n),
    .rd_n(rd_n), .wr_n(wr_n), .wait_n(wait_n));
  ebw_ext_mem i_mem (.clk(clk), .ext_addr(ext_addr), .ext_data_o(ext_data_o),
    .ext_data_oe_n(ext_data_oe_n), .addr_strobe_n(addr_strobe_n), .rd_n(rd_n),
    .wr_n(wr_n), .low_len(low_len), .ext_data_i(ext_data_i), .wait_n(wait_n));

  // Compare one value and count it
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [APB_AW-1:0] ad, input logic [7:0] d,
    output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register write, discarding the answer
  task automatic setreg(input logic [APB_AW-1:0] ad, input logic [7:0] d);
    logic [31:0] rr;
    logic ee;
    apb(1'b1, ad, d, rr, ee);
  endtask

  // One CPU access; checks latency, strobe counts and read data
  task automatic cpu(input logic wr, input logic onc, input logic [EXT_AW-1:0] ad,
    input logic [7:0] d, input int lat);
    int n, strb_cnt, rw_cnt;
    n = 0;
    strb_cnt = 0;
    rw_cnt = 0;
    @(posedge clk);
    cpu_req <= 1'b1;
    cpu_wr <= wr;
    cpu_onchip <= onc;
    cpu_addr <= ad;
    cpu_wdata <= d;
    do begin
      @(negedge clk);
      n++;
      if (addr_strobe_n === 1'b0) strb_cnt++;
      if ((wr ? wr_n : rd_n) === 1'b0) rw_cnt++;
    end while (cpu_done !== 1'b1 && n < 40);
    @(posedge clk);
    cpu_req <= 1'b0;
    chk("latency", n - 1, lat);
    chk("addr strobe states", strb_cnt, onc ? 0 : lat - 1);
    chk("rw strobe states", rw_cnt, onc ? 0 : (wr ? lat - 2 : lat - 1));
    if (!wr && !onc) chk("read byte", cpu_rdata, d);
  endtask

  // Closing verdict
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #150000;
    bad_count++;
    complete_run;
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_ACCESS_STATE, 8'h00, r, e);
    chk("access state reset", r, 32'hFF);
    apb(1'b0, ADDR_WAIT_CONTROL, 8'h00, r, e);
    chk("wait control reset", r, 32'hF3);
    apb(1'b0, ADDR_WAIT_ENABLE, 8'h00, r, e);
    chk("wait enable reset", r, 32'hFF);
    apb(1'b0, 18'h00100, 8'h00, r, e);
    chk("unmapped read data", r, 32'h0);
    chk("unmapped error", e, 1'b1);
    $display("reset test done");
    // Register write lands mid-cycle: current cycle keeps three states and three waits
    fork
      cpu(1'b1, 1'b0, 20'h00010, 8'h11, 7);
      begin
        repeat (3) @(posedge clk);
        setreg(ADDR_ACCESS_STATE, 8'h00);
      end
    join
    cpu(1'b1, 1'b0, 20'h00011, 8'h22, 3);
    $display("write timing test done");
    foreach (rows[i]) begin
      setreg(ADDR_ACCESS_STATE, rows[i].ast ? 8'hFF : 8'h00);
      setreg(ADDR_WAIT_ENABLE, rows[i].wce ? 8'hFF : 8'h00);
      setreg(ADDR_WAIT_CONTROL, {4'hF, rows[i].mode, rows[i].cnt});
      low_len <= rows[i].low;
      a = {rows[i].area, 17'h0} + 20'(i % 4);
      cpu(1'b1, 1'b0, a, 8'(8'hA0 + i), int'(rows[i].lat));
      cpu(1'b0, 1'b0, a, 8'(8'hA0 + i), int'(rows[i].lat));
      $display("row %0d done", i);
    end
    // Per-area bits: area 2 two-state, area 5 pin mode 0, others count 1
    setreg(ADDR_ACCESS_STATE, 8'hFB);
    setreg(ADDR_WAIT_ENABLE, 8'hDF);
    setreg(ADDR_WAIT_CONTROL, {4'hF, WMODE_PROG, 2'h1});
    low_len <= 4'h2;
    cpu(1'b1, 1'b0, 20'h3FFFF, 8'h33, 5);
    cpu(1'b1, 1'b0, 20'h40000, 8'h44, 3);
    cpu(1'b1, 1'b0, 20'hA0000, 8'h55, 6);
    $display("area test done");
    cpu(1'b0, 1'b1, 20'h00000, 8'h00, 3);
    $display("on-chip test done");
    // Write with byte strobe off leaves the register alone
    pstrb <= 4'h0;
    setreg(ADDR_WAIT_CONTROL, 8'hF0);
    pstrb <= 4'hF;
    apb(1'b0, ADDR_WAIT_CONTROL, 8'h00, r, e);
    chk("strobe-less write", r, 32'hF1);
    $display("strobe test done");
    // Mid-run reset brings the wait control and access state registers back to their defaults
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_WAIT_CONTROL, 8'h00, r, e);
    chk("wait control after reset", r, 32'hF3);
    apb(1'b0, ADDR_ACCESS_STATE, 8'h00, r, e);
    chk("access state after reset", r, 32'hFF);
    $display("mid-run reset test done");
    complete_run;
  end
endmodule
